//--- inc/ftsc_pkg.sv
// Shared constants and types for the FIFO tag and software clear block.
package ftsc_pkg;

    // ==========================================================
    // Word layout
    // ==========================================================
    localparam int WORD_W  = 16;
    localparam int TAG_W   = 4;
    localparam int VALUE_W = 12;
    localparam int TAG_LSB = 12;

    // ==========================================================
    // Source tag codes
    // ==========================================================
    localparam logic [3:0] TAG_DIE_TEMP  = 4'h0;
    localparam logic [3:0] TAG_CH1_TEMP  = 4'h1;
    localparam logic [3:0] TAG_CH1_CURR  = 4'h2;
    localparam logic [3:0] TAG_AUX_ONE   = 4'h3;
    localparam logic [3:0] TAG_CH2_TEMP  = 4'h4;
    localparam logic [3:0] TAG_CH2_CURR  = 4'h5;
    localparam logic [3:0] TAG_AUX_TWO   = 4'h6;
    localparam logic [3:0] TAG_CH1_TAVG  = 4'h8;
    localparam logic [3:0] TAG_CH1_PAVG  = 4'h9;
    localparam logic [3:0] TAG_CH2_TAVG  = 4'ha;
    localparam logic [3:0] TAG_CH2_PAVG  = 4'hb;
    localparam logic [3:0] TAG_ERROR     = 4'he;
    localparam logic [3:0] TAG_EMPTY     = 4'hf;

    // ==========================================================
    // Software clear register bit positions
    // ==========================================================
    localparam int SC_CH1_CONV_CLR  = 0;
    localparam int SC_CH2_CONV_CLR  = 1;
    localparam int SC_QUEUE_CLR     = 2;
    localparam int SC_AVG_MEM_CLR   = 3;
    localparam int SC_ALARM_THR_CLR = 4;
    localparam int SC_FULL_ARM      = 5;
    localparam int SC_FULL_TRIGGER  = 6;

    // ==========================================================
    // Flag register layout
    // ==========================================================
    localparam int FLAG_RESTART = 10;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [3:0] {
        FTSC_SRC_DIE_TEMP,
        FTSC_SRC_CH1_TEMP,
        FTSC_SRC_CH1_CURR,
        FTSC_SRC_AUX_ONE,
        FTSC_SRC_CH2_TEMP,
        FTSC_SRC_CH2_CURR,
        FTSC_SRC_AUX_TWO,
        FTSC_SRC_CH1_TAVG,
        FTSC_SRC_CH1_PAVG,
        FTSC_SRC_CH2_TAVG,
        FTSC_SRC_CH2_PAVG
    } ftsc_src_t;

    typedef struct packed {
        ftsc_src_t          src;
        logic [VALUE_W-1:0] value;
    } ftsc_sample_t;

    typedef struct packed {
        logic [TAG_W-1:0]   tag;
        logic [VALUE_W-1:0] value;
    } ftsc_word_t;

    typedef struct packed {
        logic ch1ConvClr;
        logic ch2ConvClr;
        logic queueClr;
        logic avgMemClr;
        logic alarmThrClr;
        logic fullReset;
    } ftsc_clr_t;

    typedef enum logic [1:0] {
        FTSC_IDLE,
        FTSC_ARMED,
        FTSC_RESETTING
    } ftsc_state_t;

endpackage : ftsc_pkg

//--- core/ftsc_rst_sync.sv
// Reset release synchroniser for the FIFO tag and software clear block.
`timescale 1ns/1ps
module ftsc_rst_sync (
    input  wire logic clk_sys,
    input  wire logic nrst,
    output logic      nrstSync
);

    logic stage1_r;
    logic stage2_r;

    // ==========================================================
    // Two flip-flop release
    // ==========================================================
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            stage1_r <= 1'b0;
            stage2_r <= 1'b0;
        end else begin
            stage1_r <= 1'b1;
            stage2_r <= stage1_r;
        end
    end

    assign nrstSync = stage2_r;

endmodule : ftsc_rst_sync

//--- core/ftsc_top.sv
// FIFO source tagging, FIFO read formatting and software clear control.
`timescale 1ns/1ps
module ftsc_top
    import ftsc_pkg::*;
#(
    parameter int VALUE_BITS = VALUE_W
) (
    input  wire logic         clk_sys,
    input  wire logic         nrst,
    input  wire logic         clkEn,
    input  wire logic         convMonEn,
    input  wire logic         avgMonEn,
    input  wire logic         smpValid,
    input  wire ftsc_sample_t smpIn,
    output logic              queuePush,
    output ftsc_word_t        queueWord,
    input  wire logic         rdReq,
    input  wire logic         queueEmpty,
    input  wire ftsc_word_t   queueHead,
    input  wire logic         queueHeadErr,
    output logic              queuePop,
    output logic              rdValid,
    output ftsc_word_t        rdWord,
    input  wire logic [11:0]  flagIn,
    input  wire logic         flagRead,
    output logic              restartFlag,
    input  wire logic         swClrWr,
    input  wire logic [15:0]  swClrData,
    output ftsc_clr_t         clrOut,
    output logic              fullArmed,
    output logic              fullTrigBit
);

    // ==========================================================
    // Elaboration check
    // ==========================================================
    if (VALUE_BITS != VALUE_W) begin : gBadWidth
        $error("ftsc_top supports only a 12-bit value field.");
    end

    // ==========================================================
    // Reset synchroniser
    // ==========================================================
    logic rstN;

    ftsc_rst_sync uRstSync (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .nrstSync (rstN)
    );

    // ==========================================================
    // Source tag encoding
    // ==========================================================
    function automatic logic [3:0] srcTag(input ftsc_src_t src);
        logic [3:0] tag;
        tag = TAG_DIE_TEMP;
        unique case (src)
            FTSC_SRC_DIE_TEMP: tag = TAG_DIE_TEMP;
            FTSC_SRC_CH1_TEMP: tag = TAG_CH1_TEMP;
            FTSC_SRC_CH1_CURR: tag = TAG_CH1_CURR;
            FTSC_SRC_AUX_ONE:  tag = TAG_AUX_ONE;
            FTSC_SRC_CH2_TEMP: tag = TAG_CH2_TEMP;
            FTSC_SRC_CH2_CURR: tag = TAG_CH2_CURR;
            FTSC_SRC_AUX_TWO:  tag = TAG_AUX_TWO;
            FTSC_SRC_CH1_TAVG: tag = TAG_CH1_TAVG;
            FTSC_SRC_CH1_PAVG: tag = TAG_CH1_PAVG;
            FTSC_SRC_CH2_TAVG: tag = TAG_CH2_TAVG;
            FTSC_SRC_CH2_PAVG: tag = TAG_CH2_PAVG;
            default:           tag = TAG_ERROR;
        endcase
        return tag;
    endfunction : srcTag

    // ==========================================================
    // Sample admission
    // ==========================================================
    wire isAvgSrc  = (smpIn.src >= FTSC_SRC_CH1_TAVG);
    wire srcLegal  = (smpIn.src <= FTSC_SRC_CH2_PAVG);
    wire admitConv = smpValid && srcLegal && !isAvgSrc && convMonEn;
    wire admitAvg  = smpValid && srcLegal && isAvgSrc && avgMonEn;
    wire admit     = admitConv || admitAvg;

    ftsc_word_t pushWord_nxt;
    assign pushWord_nxt.tag   = srcTag(smpIn.src);
    assign pushWord_nxt.value = smpIn.value;

    logic       queuePush_r;
    ftsc_word_t queueWord_r;

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            queuePush_r <= 1'b0;
            queueWord_r <= WORD_RST;
        end else if (clkEn) begin
            queuePush_r <= admit && !clrOut.queueClr;
            if (admit) begin
                queueWord_r <= pushWord_nxt;
            end
        end
    end

    assign queuePush = queuePush_r;
    assign queueWord = queueWord_r;

    // ==========================================================
    // Read formatting
    // ==========================================================
    logic restart_r;

    wire [11:0] flagView = {flagIn[11], restart_r, flagIn[9:0]};

    ftsc_word_t rdWord_nxt;
    assign rdWord_nxt.tag   = queueEmpty   ? TAG_EMPTY :
                              queueHeadErr ? TAG_ERROR :
                              queueHead.tag;
    assign rdWord_nxt.value = queueEmpty ? flagView : queueHead.value;

    assign queuePop = rdReq && !queueEmpty && clkEn;

    logic       rdValid_r;
    ftsc_word_t rdWord_r;

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            rdValid_r <= 1'b0;
            rdWord_r  <= WORD_RST;
        end else if (clkEn) begin
            rdValid_r <= rdReq;
            if (rdReq) begin
                rdWord_r <= rdWord_nxt;
            end
        end
    end

    assign rdValid = rdValid_r;
    assign rdWord  = rdWord_r;

    // ==========================================================
    // Software clear decode
    // ==========================================================
    ftsc_state_t state_r;
    ftsc_state_t state_nxt;

    wire wrArm   = swClrWr && swClrData[SC_FULL_ARM] && !swClrData[SC_FULL_TRIGGER];
    wire wrTrig  = swClrWr && swClrData[SC_FULL_TRIGGER];
    wire trigGo  = wrTrig && (state_r == FTSC_ARMED);

    ftsc_clr_t clr_nxt;
    assign clr_nxt.alarmThrClr = swClrWr && swClrData[SC_ALARM_THR_CLR];
    assign clr_nxt.avgMemClr   = swClrWr && swClrData[SC_AVG_MEM_CLR];
    assign clr_nxt.queueClr    = swClrWr && swClrData[SC_QUEUE_CLR];
    assign clr_nxt.ch2ConvClr  = swClrWr && swClrData[SC_CH2_CONV_CLR];
    assign clr_nxt.ch1ConvClr  = swClrWr && swClrData[SC_CH1_CONV_CLR];
    assign clr_nxt.fullReset   = trigGo;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            FTSC_IDLE: begin
                if (wrArm) begin
                    state_nxt = FTSC_ARMED;
                end
            end
            FTSC_ARMED: begin
                if (trigGo) begin
                    state_nxt = FTSC_RESETTING;
                end else if (swClrWr && !swClrData[SC_FULL_ARM]) begin
                    state_nxt = FTSC_IDLE;
                end
            end
            FTSC_RESETTING: begin
                state_nxt = wrArm ? FTSC_ARMED : FTSC_IDLE;
            end
        endcase
    end

    logic      fullTrigBit_r;
    ftsc_clr_t clr_r;

    // A trigger write that is not armed leaves the stored bit alone.
    wire trigBit_nxt = trigGo ? 1'b1 :
                       (swClrWr && state_r == FTSC_ARMED) ? swClrData[SC_FULL_TRIGGER] :
                       fullTrigBit_r;

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            state_r       <= FTSC_IDLE;
            clr_r         <= '0;
            fullTrigBit_r <= 1'b0;
        end else if (clkEn) begin
            state_r       <= state_nxt;
            clr_r         <= clr_nxt;
            fullTrigBit_r <= trigBit_nxt;
        end
    end

    assign clrOut      = clr_r;
    assign fullArmed   = (state_r == FTSC_ARMED);
    assign fullTrigBit = fullTrigBit_r;

    // ==========================================================
    // Restart flag
    // ==========================================================
    wire resetDone = (state_r == FTSC_RESETTING);

    // Completion wins over a read in the same cycle.
    wire restart_nxt = resetDone ? 1'b1 :
                       flagRead  ? 1'b0 :
                       restart_r;

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            restart_r <= 1'b0;
        end else if (clkEn) begin
            restart_r <= restart_nxt;
        end
    end

    assign restartFlag = restart_r;

endmodule : ftsc_top

//--- tb/ftsc_props.sv
// Concurrent checks on the ports of the FIFO tag and software clear block.
`timescale 1ns/1ps
module ftsc_props
    import ftsc_pkg::*;
(
    input wire logic         clk_sys,
    input wire logic         nrst,
    input wire logic         clkEn,
    input wire logic         convMonEn,
    input wire logic         avgMonEn,
    input wire logic         smpValid,
    input wire ftsc_sample_t smpIn,
    input wire logic         queuePush,
    input wire ftsc_word_t   queueWord,
    input wire logic         rdReq,
    input wire logic         queueEmpty,
    input wire logic         queueHeadErr,
    input wire ftsc_word_t   rdWord,
    input wire logic         restartFlag,
    input wire logic         swClrWr,
    input wire logic [15:0]  swClrData,
    input wire ftsc_clr_t    clrOut,
    input wire logic         fullArmed,
    input wire logic         fullTrigBit
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    wire rdGo  = clkEn && rdReq;
    wire smpGo = clkEn && smpValid;
    wire clrGo = clkEn && swClrWr;
    sequence armWrite;
        clrGo && swClrData[5] && !swClrData[6] && !fullArmed;
    endsequence
    sequence trigWrite;
        clrGo && swClrData[6] && fullArmed;
    endsequence
    chk_empty_tag: assert property (rdGo && queueEmpty |=> rdWord.tag == TAG_EMPTY)
        else $error("empty read tag wrong");
    chk_err_tag: assert property (
        rdGo && !queueEmpty && queueHeadErr |=> rdWord.tag == TAG_ERROR)
        else $error("error tag missing");
    chk_raw_gate: assert property (
        smpGo && !convMonEn && smpIn.src <= FTSC_SRC_AUX_TWO |=> !queuePush)
        else $error("raw sample pushed while disabled");
    chk_avg_gate: assert property (
        smpGo && !avgMonEn && smpIn.src > FTSC_SRC_AUX_TWO |=> !queuePush)
        else $error("average pushed while disabled");
    chk_tag_legal: assert property (
        queuePush |-> !(queueWord.tag inside {4'h7, 4'hc, 4'hd}))
        else $error("undefined tag pushed");
    chk_arm_step: assert property (armWrite |=> fullArmed)
        else $error("arming write ignored");
    chk_trig_fire: assert property (trigWrite |=> clrOut.fullReset && fullTrigBit)
        else $error("armed trigger ignored");
    chk_no_trig: assert property (
        clrGo && swClrData[6] && !fullArmed |=> !clrOut.fullReset && $stable(fullTrigBit))
        else $error("unarmed trigger acted");
    chk_restart_set: assert property (trigWrite ##1 clrOut.fullReset |=> restartFlag)
        else $error("restart flag not set");
    chk_queue_clr: assert property (
        clrGo && swClrData[2] |=> clrOut.queueClr ##1 !clrOut.queueClr)
        else $error("queue clear pulse wrong");
endmodule : ftsc_props
bind ftsc_top ftsc_props ftsc_props_inst (.clk_sys, .nrst, .clkEn, .convMonEn, .avgMonEn,
    .smpValid, .smpIn, .queuePush, .queueWord, .rdReq, .queueEmpty, .queueHeadErr, .rdWord,
    .restartFlag, .swClrWr, .swClrData, .clrOut, .fullArmed, .fullTrigBit);

//--- tb/ftsc_fifo_model.sv
// Behavioural result queue standing on the far side of the block.
`timescale 1ns/1ps
module ftsc_fifo_model
    import ftsc_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    input  wire logic       queuePush,
    input  wire ftsc_word_t queueWord,
    input  wire logic       queuePop,
    input  wire logic       queueClr,
    input  wire logic       errMark,
    output logic            queueEmpty,
    output ftsc_word_t      queueHead,
    output logic            queueHeadErr
);
    ftsc_word_t store[$];
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            store.delete();
            queueEmpty <= 1'h1;
            queueHead <= 16'hffff;
            queueHeadErr <= 1'h0;
        end else begin
            if (queueClr) begin
                store.delete();
            end else begin
                if (queuePop && store.size() > 0)
                    void'(store.pop_front());
                if (queuePush)
                    store.push_back(queueWord);
            end
            queueEmpty <= store.size() == 0;
            queueHead <= store.size() > 0 ? store[0] : ~queueHead;
            queueHeadErr <= errMark && store.size() > 0;
        end
    end
endmodule : ftsc_fifo_model

//--- tb/ftsc_top_tb.sv
// Self-checking testbench for the FIFO tag and software clear block.
`timescale 1ns/1ps
module ftsc_top_tb
    import ftsc_pkg::*;
;
    logic clk_sys = 1'h0, nrst = 1'h0, convMonEn = 1'h0, avgMonEn = 1'h0;
    logic smpValid = 1'h0, rdReq = 1'h0, flagRead = 1'h0, swClrWr = 1'h0, errMark = 1'h0;
    logic clkEn = 1'h1;
    logic [11:0] flagIn = 12'hd3c;
    logic [15:0] swClrData = 16'h0000;
    ftsc_sample_t smpIn = 16'h0000;
    logic queuePush, queuePop, rdValid, restartFlag, fullArmed, fullTrigBit;
    logic queueEmpty, queueHeadErr;
    ftsc_word_t queueWord, queueHead, rdWord;
    ftsc_clr_t clrOut;
    int err_total = 0;
    int checked = 0;
    ftsc_top ftsc_top_inst (.clk_sys, .nrst, .clkEn, .convMonEn, .avgMonEn, .smpValid,
        .smpIn, .queuePush, .queueWord, .rdReq, .queueEmpty, .queueHead, .queueHeadErr,
        .queuePop, .rdValid, .rdWord, .flagIn, .flagRead, .restartFlag, .swClrWr,
        .swClrData, .clrOut, .fullArmed, .fullTrigBit);
    ftsc_fifo_model ftsc_fifo_model_inst (.clk_sys, .nrst, .queuePush, .queueWord, .queuePop,
        .queueClr(clrOut.queueClr), .errMark, .queueEmpty, .queueHead, .queueHeadErr);
    initial forever #25 clk_sys = ~clk_sys;
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic step();
        @(posedge clk_sys);
        #5;
    endtask : step
    task automatic smp(input int s, input logic [11:0] v);
        smpIn = {4'(s), v};
        smpValid = 1'h1;
        step();
        smpValid = 1'h0;
        step();
    endtask : smp
    task automatic rd(input logic [15:0] e);
        rdReq = 1'h1;
        step();
        rdReq = 1'h0;
        chk("rdValid", 16'h0001, 16'(rdValid));
        chk("rdWord", e, rdWord);
        step();
    endtask : rd
    task automatic wr(input logic [15:0] d, input logic [5:0] e);
        swClrData = d;
        swClrWr = 1'h1;
        step();
        swClrWr = 1'h0;
        chk("clrOut", 16'(e), 16'(clrOut));
        step();
    endtask : wr
    task automatic report_and_stop();
        if (err_total == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        #500000;
        err_total++;
        report_and_stop();
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        #5 nrst = 1'h1;
        repeat (3) step();
        rd(16'hf93c);
        clkEn = 1'h0;
        wr(16'h0020, 6'h00);
        chk("fullArmed", 16'h0000, 16'(fullArmed));
        clkEn = 1'h1;
        convMonEn = 1'h1;
        for (int i = 0; i < 11; i++) smp(i, 12'(i * 273));
        for (int i = 0; i < 7; i++) rd({4'(i), 12'(i * 273)});
        rd(16'hf93c);
        convMonEn = 1'h0;
        avgMonEn = 1'h1;
        for (int i = 0; i < 11; i++) smp(i, 12'(i * 273));
        for (int i = 7; i < 11; i++) rd({4'(i + 1), 12'(i * 273)});
        smp(8, 12'h5a5);
        errMark = 1'h1;
        step();
        rd(16'he5a5);
        errMark = 1'h0;
        smp(9, 12'h123);
        smp(10, 12'h456);
        wr(16'hff80, 6'h00);
        for (int i = 0; i < 5; i++) wr(16'(1 << i), 6'(32 >> i));
        rd(16'hf93c);
        wr(16'h0040, 6'h00);
        chk("fullTrigBit", 16'h0000, 16'(fullTrigBit));
        wr(16'h0020, 6'h00);
        chk("fullArmed", 16'h0001, 16'(fullArmed));
        wr(16'h0040, 6'h01);
        chk("fullTrigBit", 16'h0001, 16'(fullTrigBit));
        chk("restartFlag", 16'h0001, 16'(restartFlag));
        wr(16'h0040, 6'h00);
        chk("fullTrigBit", 16'h0001, 16'(fullTrigBit));
        flagIn = 12'h2c1;
        rd(16'hf6c1);
        flagRead = 1'h1;
        step();
        flagRead = 1'h0;
        step();
        chk("restartFlag", 16'h0000, 16'(restartFlag));
        report_and_stop();
    end
endmodule : ftsc_top_tb
